// ===== regulator_voltage_code_regs.sv
/*
  Register bank holding the voltage codes of step-down rails 4, 5, 6
  and the drivers that pick each rail's applied code and ramp it on rails 5 and 6.
  Assumes a serial bus slave presents byte writes and reads by offset,
  and that the range and sleep inputs come from the power sequencer.
*/
module regulator_voltage_code_regs
  import vcode_pkg::*;
#(
  parameter logic [7:0] RAIL4_SLEEP_INIT = RAIL4_SLEEP_RESET,
  parameter logic [7:0] RAIL5_NORMAL_INIT = RAIL5_NORMAL_RESET,
  parameter logic [7:0] RAIL5_SLEEP_INIT = RAIL5_SLEEP_RESET,
  parameter logic [7:0] RAIL6_NORMAL_INIT = RAIL6_NORMAL_RESET
)(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic rail4_sleep,
  input wire logic rail5_sleep,
  input wire logic rail4_coarse,
  input wire logic rail5_coarse,
  input wire logic rail6_coarse,
  input wire logic [6:0] rail4_normal_code,
  output logic [6:0] rail4_code,
  output logic [6:0] rail5_code,
  output logic [6:0] rail6_code,
  output logic [15:0] rail4_step_uv,
  output logic [15:0] rail5_step_uv,
  output logic [15:0] rail6_step_uv
);
  logic [7:0] r4s_reg, r4s_next, r5n_reg, r5n_next;
  logic [7:0] r5s_reg, r5s_next, r6n_reg, r6n_next;
  logic [7:0] rdata_reg, rdata_next;
  logic hit_reg, hit_next;
  logic sel_r4s, sel_r5n, sel_r5s, sel_r6n;
  logic [6:0] r5n_code, r6n_code;
  logic [6:0] c4, c5, c6, c4_reg, c5_reg, c6_reg;
  logic [6:0] c4_next, c5_next, c6_next;
  logic [15:0] s4, s5, s6, s4_reg, s5_reg, s6_reg;
  logic [15:0] s4_next, s5_next, s6_next;

  // one offset decoder serves both the write and the read path
  always_comb begin
    sel_r4s = 1'b0;
    sel_r5n = 1'b0;
    sel_r5s = 1'b0;
    sel_r6n = 1'b0;
    if (reg_addr == RAIL4_SLEEP_OFS) begin
      sel_r4s = 1'b1;
    end else if (reg_addr == RAIL5_NORMAL_OFS) begin
      sel_r5n = 1'b1;
    end else if (reg_addr == RAIL5_SLEEP_OFS) begin
      sel_r5s = 1'b1;
    end else if (reg_addr == RAIL6_NORMAL_OFS) begin
      sel_r6n = 1'b1;
    end
  end

  always_comb begin
    r4s_next = r4s_reg;
    r5n_next = r5n_reg;
    r5s_next = r5s_reg;
    r6n_next = r6n_reg;
    if (reg_wr) begin
      if (sel_r4s) begin
        r4s_next = reg_wdata & RESERVED_MASK;
      end else if (sel_r5n) begin
        r5n_next = reg_wdata;
      end else if (sel_r5s) begin
        r5s_next = reg_wdata & RESERVED_MASK;
      end else if (sel_r6n) begin
        r6n_next = reg_wdata;
      end
    end
  end

  // unmapped offsets read as zero and leave the hit flag low
  always_comb begin
    rdata_next = rdata_reg;
    hit_next = 1'b0;
    if (reg_rd) begin
      hit_next = 1'b1;
      if (sel_r4s) begin
        rdata_next = r4s_reg;
      end else if (sel_r5n) begin
        rdata_next = r5n_reg;
      end else if (sel_r5s) begin
        rdata_next = r5s_reg;
      end else if (sel_r6n) begin
        rdata_next = r6n_reg;
      end else begin
        rdata_next = 8'h00;
        hit_next = 1'b0;
      end
    end
  end

  // sleep registers keep bit 0 clear from reset onwards
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r4s_reg <= RAIL4_SLEEP_INIT & RESERVED_MASK;
      r5n_reg <= RAIL5_NORMAL_INIT;
      r5s_reg <= RAIL5_SLEEP_INIT & RESERVED_MASK;
      r6n_reg <= RAIL6_NORMAL_INIT;
    end else begin
      r4s_reg <= r4s_next;
      r5n_reg <= r5n_next;
      r5s_reg <= r5s_next;
      r6n_reg <= r6n_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
      hit_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
    end
  end

  // while reset is held the rail 5 and 6 steppers load the factory codes directly,
  // so a single reset edge leaves no unknown applied code behind
  always_comb begin
    r5n_code = r5n_reg[CODE_MSB:CODE_LSB];
    r6n_code = r6n_reg[CODE_MSB:CODE_LSB];
    if (!rstn) begin
      r5n_code = RAIL5_NORMAL_INIT[CODE_MSB:CODE_LSB];
      r6n_code = RAIL6_NORMAL_INIT[CODE_MSB:CODE_LSB];
    end
  end

  // rail 4 normal code lives elsewhere and never slews here; rail 6 has
  // no sleep code in this bank
  rail_target u_rail4 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .normal_code(rail4_normal_code),
    .sleep_code(r4s_reg[CODE_MSB:CODE_LSB]),
    .sleep_active(rail4_sleep),
    .passive_ramp_down(1'b1),
    .coarse_range(rail4_coarse),
    .applied_code(c4),
    .step_uv(s4)
  );

  rail_target u_rail5 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .normal_code(r5n_code),
    .sleep_code(r5s_reg[CODE_MSB:CODE_LSB]),
    .sleep_active(rail5_sleep),
    .passive_ramp_down(r5n_reg[RAMP_BIT]),
    .coarse_range(rail5_coarse),
    .applied_code(c5),
    .step_uv(s5)
  );

  rail_target u_rail6 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .normal_code(r6n_code),
    .sleep_code(r6n_reg[CODE_MSB:CODE_LSB]),
    .sleep_active(1'b0),
    .passive_ramp_down(r6n_reg[RAMP_BIT]),
    .coarse_range(rail6_coarse),
    .applied_code(c6),
    .step_uv(s6)
  );

  // output stage keeps every pin straight off a flip-flop
  always_comb begin
    c4_next = c4;
    c5_next = c5;
    c6_next = c6;
    s4_next = s4;
    s5_next = s5;
    s6_next = s6;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      c4_reg <= 7'h00;
      c5_reg <= 7'h00;
      c6_reg <= 7'h00;
      s4_reg <= FINE_STEP_UV;
      s5_reg <= FINE_STEP_UV;
      s6_reg <= FINE_STEP_UV;
    end else begin
      c4_reg <= c4_next;
      c5_reg <= c5_next;
      c6_reg <= c6_next;
      s4_reg <= s4_next;
      s5_reg <= s5_next;
      s6_reg <= s6_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_hit = hit_reg;
  assign rail4_code = c4_reg;
  assign rail5_code = c5_reg;
  assign rail6_code = c6_reg;
  assign rail4_step_uv = s4_reg;
  assign rail5_step_uv = s5_reg;
  assign rail6_step_uv = s6_reg;
endmodule

// ===== vcode_pkg.sv
/*
  Constants for the step-down rail voltage code register bank: byte
  offsets, field positions, factory reset patterns and code units.
  Assumes one 8-bit register access port from the serial bus slave.
*/
package vcode_pkg;
  localparam logic [7:0] RAIL4_SLEEP_OFS = 8'h95;
  localparam logic [7:0] RAIL5_NORMAL_OFS = 8'h96;
  localparam logic [7:0] RAIL5_SLEEP_OFS = 8'h97;
  localparam logic [7:0] RAIL6_NORMAL_OFS = 8'h98;
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 1;
  localparam int RAMP_BIT = 0;
  localparam logic [7:0] RAIL4_SLEEP_RESET = 8'h28;
  localparam logic [7:0] RAIL5_NORMAL_RESET = 8'h70;
  localparam logic [7:0] RAIL5_SLEEP_RESET = 8'h70;
  localparam logic [7:0] RAIL6_NORMAL_RESET = 8'hBE;
  localparam logic [7:0] RESERVED_MASK = 8'hFE;
  localparam logic [15:0] FINE_STEP_UV = 16'h2710;
  localparam logic [15:0] COARSE_STEP_UV = 16'h61A8;
  localparam int SLEW_STEP_CYCLES = 200;
  localparam logic [7:0] SLEW_STEP_COUNT = 8'(SLEW_STEP_CYCLES - 1);
  localparam int CODE_W = 7;
endpackage

// ===== rail_target.sv
/*
  One rail's target selector and active slew stepper.
  Assumes codes and mode bits come from the register bank.
*/
module rail_target
  import vcode_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [6:0] normal_code,
  input wire logic [6:0] sleep_code,
  input wire logic sleep_active,
  input wire logic passive_ramp_down,
  input wire logic coarse_range,
  output logic [6:0] applied_code,
  output logic [15:0] step_uv
);
  logic [6:0] applied_reg, applied_next, target;
  logic [7:0] cnt_reg, cnt_next;
  logic [15:0] step_reg, step_next;

  always_comb begin
    target = sleep_active ? sleep_code : normal_code;
    applied_next = applied_reg;
    cnt_next = cnt_reg;
    step_next = coarse_range ? COARSE_STEP_UV : FINE_STEP_UV;
    if (target >= applied_reg) begin
      applied_next = target;
      cnt_next = SLEW_STEP_COUNT;
    end else if (passive_ramp_down) begin
      applied_next = target;
      cnt_next = SLEW_STEP_COUNT;
    end else if (cnt_reg == 8'h00) begin
      applied_next = applied_reg - 7'h01;
      cnt_next = SLEW_STEP_COUNT;
    end else begin
      cnt_next = cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      applied_reg <= normal_code;
      cnt_reg <= SLEW_STEP_COUNT;
      step_reg <= FINE_STEP_UV;
    end else begin
      applied_reg <= applied_next;
      cnt_reg <= cnt_next;
      step_reg <= step_next;
    end
  end

  assign applied_code = applied_reg;
  assign step_uv = step_reg;
endmodule

// ===== regulator_voltage_code_regs_checker.sv
/* Port assertions for the rail voltage code bank.
   Bound to every regulator_voltage_code_regs instance. */
module regulator_voltage_code_regs_checker
  import vcode_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic rail4_sleep,
  input wire logic rail5_sleep,
  input wire logic rail5_coarse,
  input wire logic [6:0] rail4_normal_code,
  input wire logic [6:0] rail4_code,
  input wire logic [6:0] rail5_code,
  input wire logic [15:0] rail5_step_uv
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic map;
  assign map = reg_addr inside {[RAIL4_SLEEP_OFS:RAIL6_NORMAL_OFS]};
  // rail 5 normal code lowered by two codes or more
  sequence lower5(logic p);
    reg_wr && reg_addr == RAIL5_NORMAL_OFS && reg_wdata[0] == p &&
    8'(reg_wdata[7:1]) + 8'h02 <= 8'(rail5_code) && !rail5_sleep;
  endsequence
  AST_HIT: assert property (reg_rd && map |=> reg_hit)
    else $error("no hit");
  AST_UNMAP: assert property (reg_rd && !map |=> !reg_hit && !reg_rdata)
    else $error("unmapped read");
  AST_BIT0: assert property (reg_rd && map && reg_addr[0] |=> !reg_rdata[0])
    else $error("reserved bit set");
  AST_HIT_CAUSE: assert property (reg_hit |-> $past(reg_rd))
    else $error("stray hit");
  AST_STEP: assert property ($stable(rail5_coarse)[*3] |->
    rail5_step_uv == (rail5_coarse ? COARSE_STEP_UV : FINE_STEP_UV))
    else $error("step size");
  AST_PASSIVE: assert property (lower5(1'b1) ##1
    (!reg_wr && !rail5_sleep)[*3] |-> rail5_code == $past(reg_wdata[7:1], 3))
    else $error("no decay jump");
  AST_ACTIVE: assert property (lower5(1'b0) ##1
    (!reg_wr && !rail5_sleep)[*5] |-> rail5_code > $past(reg_wdata[7:1], 5))
    else $error("slew too fast");
  AST_SLEEP4: assert property ((!rail4_sleep &&
    $stable(rail4_normal_code))[*5] |-> rail4_code == rail4_normal_code)
    else $error("rail 4 code");
endmodule
bind regulator_voltage_code_regs regulator_voltage_code_regs_checker u_chk (.*);

// ===== host_model.sv
/* Host issuing single byte writes and reads.
   Assumes requests are taken on the rising edge of clk_sys. */
module host_model (
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // idle lines carry inverted values so stale data never matches
  task wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk_sys);
    #1 {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
  endtask
  task rd(input logic [7:0] a, output logic [7:0] q, output logic h);
    @(posedge clk_sys);
    #1 {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk_sys);
    #1 {reg_rd, reg_addr} = {1'b0, ~a};
    q = reg_rdata;
    h = reg_hit;
  endtask
endmodule

// ===== tb_regulator_voltage_code_regs.sv
/* Bench for the rail voltage code bank.
   Needs host_model and the bound checker. */
module tb_regulator_voltage_code_regs
  import vcode_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rstn, reg_wr, reg_rd, reg_hit, h, rail4_sleep, rail5_sleep;
  logic rail4_coarse, rail5_coarse, rail6_coarse;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q, a;
  logic [6:0] rail4_normal_code, rail4_code, rail5_code, rail6_code, c;
  logic [15:0] rail4_step_uv, rail5_step_uv, rail6_step_uv;
  int miscompares, total_checks, k;
  logic [7:0] ini [4] = '{RAIL4_SLEEP_RESET, RAIL5_NORMAL_RESET,
    RAIL5_SLEEP_RESET, RAIL6_NORMAL_RESET};
  regulator_voltage_code_regs u_regulator_voltage_code_regs (.*);
  host_model u_host_model (.*);
  // odd offsets are the sleep registers with a reserved bit 0
  function automatic logic [7:0] expv(logic [7:0] a, d);
    return a[0] ? d & RESERVED_MASK : d;
  endfunction
  function automatic logic [15:0] stepv(logic k);
    return k ? COARSE_STEP_UV : FINE_STEP_UV;
  endfunction
  task chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task waitc(input int r, input logic [6:0] e);
    for (int i = 0; i < 5000 && c !== e; i++) begin
      @(posedge clk_sys);
      #1 c = r == 4 ? rail4_code : r == 5 ? rail5_code : rail6_code;
    end
    chk(c, e);
    c = 'x;
    if (miscompares > 0) wrap_up();
  endtask
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    {rstn, rail4_sleep, rail5_sleep, rail4_coarse, rail5_coarse} = '0;
    {rail6_coarse, rail4_normal_code, c} = {1'b0, 7'h30, 7'hxx};
    void'($urandom(41465));
    repeat (2) @(posedge clk_sys);
    #1 rstn = 1;
    for (int i = 0; i < 4; i++) begin
      u_host_model.rd(RAIL4_SLEEP_OFS + 8'(i), q, h);
      chk({h, q}, {1'b1, expv(RAIL4_SLEEP_OFS + 8'(i), ini[i])});
    end
    for (int n = 0; n < 24; n++) begin
      {rail4_coarse, rail5_coarse, rail6_coarse} = 3'($urandom);
      rail4_normal_code = 7'($urandom);
      a = RAIL4_SLEEP_OFS + 8'($urandom_range(3));
      q = 8'($urandom);
      u_host_model.wr(a, q);
      u_host_model.rd(a, q, h);
      chk({h, q}, {1'b1, expv(a, ~reg_wdata)});
      a = n == 0 ? 8'h94 : n == 1 ? 8'h99 : {1'b0, 7'($urandom)};
      u_host_model.rd(a, q, h);
      chk({h, q}, 9'h000);
      chk(rail4_step_uv, stepv(rail4_coarse));
      chk(rail6_step_uv, stepv(rail6_coarse));
      chk(rail5_step_uv, stepv(rail5_coarse));
    end
    u_host_model.wr(RAIL5_NORMAL_OFS, 8'hA1);
    waitc(5, 7'h50);
    u_host_model.wr(RAIL5_NORMAL_OFS, 8'h21);
    repeat (3) @(posedge clk_sys);
    #1 chk(rail5_code, 7'h10);
    u_host_model.wr(RAIL5_NORMAL_OFS, 8'h1C);
    repeat (150) @(posedge clk_sys);
    #1 chk(rail5_code, 7'h10);
    waitc(5, 7'h0F);
    for (k = 0; k < 300 && rail5_code !== 7'h0E; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(16'(k), 16'(SLEW_STEP_CYCLES));
    waitc(5, 7'h0E);
    u_host_model.wr(RAIL5_SLEEP_OFS, 8'h40);
    rail5_sleep = 1;
    waitc(5, 7'h20);
    rail5_sleep = 0;
    waitc(5, 7'h0E);
    u_host_model.wr(RAIL4_SLEEP_OFS, 8'h2A);
    rail4_sleep = 1;
    waitc(4, 7'h15);
    rail4_sleep = 0;
    waitc(4, rail4_normal_code);
    u_host_model.wr(RAIL6_NORMAL_OFS, 8'h63);
    waitc(6, 7'h31);
    rstn = 0;
    repeat (2) @(posedge clk_sys);
    #1 rstn = 1;
    u_host_model.rd(RAIL5_NORMAL_OFS, q, h);
    chk({h, q}, {1'b1, RAIL5_NORMAL_RESET});
    chk(rail5_code, RAIL5_NORMAL_RESET[CODE_MSB:CODE_LSB]);
    chk(rail6_code, RAIL6_NORMAL_RESET[CODE_MSB:CODE_LSB]);
    wrap_up();
  end
endmodule
